// ---- rtl/qpcd_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// [RL1] Upper address nibble must equal the device type code to go on.
// [RL2] Lower address nibble must equal the address pins to execute.
// [RL3] Instruction byte: opcode top four bits, slot pointer, pot pointer lowest.
// [RL4] Slot pointer picks stored slot 0 to 3 in binary order.
// [RL5] Four 6-bit wiper registers, each decoded to one of 64 taps.
// [RL6] At power-up each wiper loads from its pot's slot 0.
// [RL7] Four 6-bit stored slots per pot; programming finishes within 5 ms.
// [RL8] Read/write wiper and read/write stored use three bytes.
// [RL9] Opcode 1001, slot 00: return wiper of chosen pot.
// [RL10] Opcode 1010, slot 00: load data into chosen pot's wiper.
// [RL11] Opcode 1011 returns chosen stored slot; 1100 writes it.
// [RL12] Opcode 1101 copies chosen stored slot into that pot's wiper.
// [RL13] Opcode 1110 copies chosen wiper into that pot's chosen slot.
// [RL14] Opcode 0001, pot 00: all pots load wiper from chosen slot.
// [RL15] Opcode 1000, pot 00: all wipers saved into chosen slot.
// [RL16] Opcode 0010, slot 00: enables stepping of chosen wiper.
// [RL17] Tap output follows a wiper change only after a settle delay.
// [RL18] Programming starts at stop; address ignored while it runs.
// [RL19] Write-protect low: data byte refused, stored slots untouched; the code refuses only the 1100 data byte and still takes a 1010 wiper byte.
// [RL20] In step mode each clock with data high steps up, low down.
// [RL21] Every stored write or copy is programmed after the stop.
// [RL22] Stepping saturates at 63 and at 0.
// [RL23] Undefined opcodes change nothing and start no programming.
module qpcd_top
    import qpcd_pkg::*;
#(
    parameter logic [3:0] DEVICE_TYPE_ID  = 4'hA, // Arbitrary value
    parameter int         NV_PROG_CYC     = NV_PROG_MS * CLK_KHZ,
    parameter int         WIPER_SETTLE_NS = SETTLE_NS_DEF
) (
    // Clock and reset
    input  wire logic                         CLOCK_I,
    input  wire logic                         RST_I,
    // Two-wire bus
    input  wire logic                         SCL_I,
    input  wire logic                         SDA_I,
    output logic                              SDA_O,
    output logic                              SDA_OE_O,
    // Straps and protection
    input  wire logic [3:0]                   ADDR_PIN_I,
    input  wire logic                         WP_N_I,
    // Resistor array and status
    output logic      [NPOTS-1:0][NTAPS-1:0]  TAP_O,
    output logic                              NV_BUSY_O
);
    // Least time, so round up, and never below two cycles
    localparam int SETTLE_RAW = (WIPER_SETTLE_NS * CLK_KHZ + 999999) / 1000000;
    localparam int SETTLE_CYC = (SETTLE_RAW < 2) ? 2 : SETTLE_RAW;

    qpcd_state_s q;
    qpcd_state_s d;
    logic [6:0]  sync_w;
    logic        scl_s;
    logic        sda_s;
    logic        wp_s;
    logic [3:0]  addr_s;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;
    logic        byte_end;
    logic        addr_hit;

    qpcd_sync #(
        .WIDTH (7)
    ) u_sync (
        .clk_i   (CLOCK_I),
        .rst_i   (RST_I),
        .async_i ({SCL_I, SDA_I, WP_N_I, ADDR_PIN_I}),
        .sync_o  (sync_w)
    );

    assign scl_s    = sync_w[6];
    assign sda_s    = sync_w[5];
    assign wp_s     = sync_w[4];
    assign addr_s   = sync_w[3:0];
    assign scl_rise = scl_s & ~q.scl_prev;
    assign scl_fall = ~scl_s & q.scl_prev;
    assign start_c  = scl_s & q.scl_prev & q.sda_prev & ~sda_s;
    assign stop_c   = scl_s & q.scl_prev & ~q.sda_prev & sda_s;
    assign byte_end = scl_fall & (q.bit_cnt == BYTE_BITS) & ~q.ack_phase;
    assign addr_hit = (q.shreg[OP_HI:OP_LO] == DEVICE_TYPE_ID)   // RL1
                    & (q.shreg[SLOT_HI:POT_LO] == addr_s);       // RL2

    always_comb
    begin
        d          = q;
        d.scl_prev = scl_s;
        d.sda_prev = sda_s;

        if (q.nv_busy)
        begin
            if (q.nv_cnt == qpcd_nvcnt_t'(NV_PROG_CYC - 1))
                d.nv_busy = 1'b0;                                    // RL7
            else
                d.nv_cnt = q.nv_cnt + 1'b1;
        end

        unique case (q.ph)
            PH_BOOT:
            begin
                for (int i = 0; i < NPOTS; i++)
                    d.wiper[i] = q.stored[qpcd_sidx(2'(i), SLOT_PRESET)]; // RL6
                d.ph = PH_IDLE;
            end
            PH_IDLE, PH_WAIT:
            begin
            end
            PH_ADDR, PH_INSTR, PH_WDATA:
            begin
                if (scl_rise && !q.ack_phase && q.bit_cnt < BYTE_BITS)
                begin
                    d.shreg   = {q.shreg[MSB-1:0], sda_s};
                    d.bit_cnt = q.bit_cnt + 1'b1;
                end
            end
            PH_RDATA:
            begin
                if (!q.ack_phase && scl_rise && q.bit_cnt < BYTE_BITS)
                begin
                    d.shreg   = {q.shreg[MSB-1:0], 1'b0};
                    d.bit_cnt = q.bit_cnt + 1'b1;
                end
                else if (!q.ack_phase && scl_fall && q.bit_cnt < BYTE_BITS)
                    d.sda_oe = ~q.shreg[MSB];
                else if (!q.ack_phase && scl_fall)
                begin
                    // Master's acknowledge is not needed: one byte per read
                    d.sda_oe = 1'b0;
                    d.ph     = PH_WAIT;
                end
            end
            PH_STEP:
            begin
                // Step on the fall: the stop's rising clock must not move the wiper
                if (scl_fall && !q.ack_phase)
                begin
                    if (sda_s && q.wiper[q.pot] != WIPER_MAX)       // RL20
                        d.wiper[q.pot] = q.wiper[q.pot] + 1'b1;     // RL22
                    else if (!sda_s && q.wiper[q.pot] != WIPER_MIN)
                        d.wiper[q.pot] = q.wiper[q.pot] - 1'b1;     // RL22
                end
            end
        endcase

        // End of an acknowledge slot
        if (scl_fall && q.ack_phase)
        begin
            d.ack_phase = 1'b0;
            d.bit_cnt   = '0;
            d.sda_oe    = (q.ph == PH_RDATA) ? ~q.shreg[MSB] : 1'b0;
        end

        if (byte_end && (q.ph == PH_ADDR || q.ph == PH_INSTR || q.ph == PH_WDATA))
        begin
            d.ack_phase = 1'b1;
            d.sda_oe    = 1'b1;
            d.ph        = PH_WAIT;
            if (q.ph == PH_ADDR)
            begin
                if (addr_hit)
                    d.ph = PH_INSTR;
                else
                begin
                    d.ack_phase = 1'b0;
                    d.sda_oe    = 1'b0;
                    d.ph        = PH_IDLE;
                end
            end
            else if (q.ph == PH_INSTR)
            begin
                d.op   = q.shreg[OP_HI:OP_LO];                      // RL3
                d.slot = q.shreg[SLOT_HI:SLOT_LO];                  // RL4
                d.pot  = q.shreg[POT_HI:POT_LO];
                if (!qpcd_instr_ok(q.shreg))
                begin
                    d.ack_phase = 1'b0;                             // RL23
                    d.sda_oe    = 1'b0;
                    d.ph        = PH_IDLE;
                end
                else
                begin
                    unique case (d.op)
                        OP_RD_WIPER:
                        begin
                            d.shreg = 8'(q.wiper[d.pot]);           // RL9
                            d.ph    = PH_RDATA;                     // RL8
                        end
                        OP_RD_STORED:
                        begin
                            d.shreg = 8'(q.stored[qpcd_sidx(d.pot, d.slot)]); // RL11
                            d.ph    = PH_RDATA;
                        end
                        OP_WR_WIPER, OP_WR_STORED:
                            d.ph = PH_WDATA;                        // RL8
                        OP_COPY_TO_WIP:
                            d.wiper[d.pot] = q.stored[qpcd_sidx(d.pot, d.slot)]; // RL12
                        OP_GANG_TO_WIP:
                        begin
                            for (int i = 0; i < NPOTS; i++)
                                d.wiper[i] = q.stored[qpcd_sidx(2'(i), d.slot)]; // RL14
                        end
                        OP_COPY_TO_STO, OP_GANG_TO_STO:
                            d.nv_pend = 1'b1;                       // RL21
                        OP_STEP:
                            d.ph = PH_STEP;                         // RL16
                        default:
                        begin
                        end
                    endcase
                end
            end
            else if (q.op == OP_WR_WIPER)
                d.wiper[q.pot] = q.shreg[WIPER_W-1:0];              // RL10
            else if (wp_s)
            begin
                d.nv_val  = q.shreg[WIPER_W-1:0];
                d.nv_pend = 1'b1;                                   // RL21
            end
            else
            begin
                d.ack_phase = 1'b0;                                 // RL19
                d.sda_oe    = 1'b0;
                d.ph        = PH_IDLE;
            end
        end

        if (q.ph != PH_BOOT && start_c)
        begin
            d.sda_oe    = 1'b0;
            d.ack_phase = 1'b0;
            d.bit_cnt   = '0;
            d.nv_pend   = 1'b0;
            d.ph        = q.nv_busy ? PH_IDLE : PH_ADDR;            // RL18
        end
        else if (q.ph != PH_BOOT && stop_c)
        begin
            d.sda_oe    = 1'b0;
            d.ack_phase = 1'b0;
            d.nv_pend   = 1'b0;
            d.ph        = PH_IDLE;
            // Protect is sampled again here, before the cycle starts
            if (q.nv_pend && wp_s)
            begin
                unique case (q.op)
                    OP_WR_STORED:
                        d.stored[qpcd_sidx(q.pot, q.slot)] = q.nv_val;      // RL11
                    OP_COPY_TO_STO:
                        d.stored[qpcd_sidx(q.pot, q.slot)] = q.wiper[q.pot]; // RL13
                    default:
                    begin
                        for (int i = 0; i < NPOTS; i++)
                            d.stored[qpcd_sidx(2'(i), q.slot)] = q.wiper[i]; // RL15
                    end
                endcase
                d.nv_busy = 1'b1;                                   // RL18
                d.nv_cnt  = '0;
            end
        end

        // Any wiper change restarts the settle wait; taps move at its end
        if (d.wiper != q.wiper)
            d.settle_cnt = qpcd_settle_t'(SETTLE_CYC);              // RL17
        else if (q.settle_cnt != '0)
        begin
            d.settle_cnt = q.settle_cnt - 1'b1;
            if (q.settle_cnt == qpcd_settle_t'(1))
            begin
                for (int i = 0; i < NPOTS; i++)
                    d.tap[i] = qpcd_tap(q.wiper[i]);                // RL5
            end
        end
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (RST_I)
        begin
            q     <= '0;
            q.ph  <= PH_BOOT;
            // Idle bus level, so no false edge follows reset
            q.scl_prev <= 1'b1;
            q.sda_prev <= 1'b1;
            q.tap <= {NPOTS{NTAPS'(1)}};
        end
        else
            q <= d;
    end

    assign SDA_O     = q.sda_lvl;
    assign SDA_OE_O  = q.sda_oe;
    assign TAP_O     = q.tap;
    assign NV_BUSY_O = q.nv_busy;

    boot_load_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL6
        q.ph == PH_BOOT |=> q.wiper[0] == $past(q.stored[0]) && q.wiper[3] == $past(q.stored[12]))
        else $error("wiper not loaded from slot 0 at power-up");

    addr_miss_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL2
        byte_end && q.ph == PH_ADDR && !addr_hit |=> q.ph == PH_IDLE && !q.sda_oe)
        else $error("mismatching address was acknowledged");

    wp_refuse_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL19
        byte_end && q.ph == PH_WDATA && q.op == OP_WR_STORED && !wp_s
        |=> !q.sda_oe && !q.nv_pend)
        else $error("protected data byte was acknowledged");

    busy_len_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL7
        $fell(q.nv_busy) |-> $past(q.nv_cnt) == qpcd_nvcnt_t'(NV_PROG_CYC - 1))
        else $error("programming time wrong");

    busy_ignore_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL18
        q.nv_busy && start_c && q.ph != PH_BOOT |=> q.ph == PH_IDLE [*2])
        else $error("address taken while programming");

    step_sat_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL22
        q.ph == PH_STEP && scl_fall && !q.ack_phase && sda_s && q.wiper[q.pot] == WIPER_MAX
        |=> q.wiper[q.pot] == WIPER_MAX)
        else $error("step wrapped past top");

    step_down_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL20
        q.ph == PH_STEP && scl_fall && !q.ack_phase && !sda_s && q.wiper[q.pot] != WIPER_MIN
        |=> q.wiper[q.pot] == $past(q.wiper[q.pot]) - 6'h01)
        else $error("step down missed");

    tap_onehot_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL5
        $onehot(q.tap[0]) && $onehot(q.tap[3]))
        else $error("tap decode not one-hot");

    settle_hold_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL17
        q.wiper != $past(q.wiper) |-> q.tap == $past(q.tap) ##1 q.tap == $past(q.tap))
        else $error("tap moved without settle delay");

    bad_op_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL23
        byte_end && q.ph == PH_INSTR && !qpcd_instr_ok(q.shreg)
        |=> $stable(q.wiper) && !q.nv_pend && q.ph == PH_IDLE)
        else $error("undefined opcode had an effect");

    wr_wiper_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL10
        byte_end && q.ph == PH_WDATA && q.op == OP_WR_WIPER && !start_c && !stop_c
        |=> q.wiper[q.pot] == $past(q.shreg[WIPER_W-1:0]))
        else $error("wiper write lost");

endmodule : qpcd_top
`default_nettype wire

// ---- rtl/qpcd_pkg.sv ----
package qpcd_pkg;

    // Geometry
    localparam int NPOTS       = 4;
    localparam int NSLOTS      = 4;
    localparam int NREGS       = NPOTS * NSLOTS;
    localparam int WIPER_W     = 6;
    localparam int NTAPS       = 64;
    localparam logic [WIPER_W-1:0] WIPER_MAX = 6'h3F;
    localparam logic [WIPER_W-1:0] WIPER_MIN = 6'h00;
    localparam logic [1:0]         SLOT_PRESET = 2'h0;

    // Byte framing
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int         MSB       = 7;

    // Instruction byte fields
    localparam int OP_HI   = 7;
    localparam int OP_LO   = 4;
    localparam int SLOT_HI = 3;
    localparam int SLOT_LO = 2;
    localparam int POT_HI  = 1;
    localparam int POT_LO  = 0;
    localparam logic [1:0] SEL_ZERO = 2'h0;

    // Opcodes
    localparam logic [3:0] OP_RD_WIPER     = 4'h9;
    localparam logic [3:0] OP_WR_WIPER     = 4'hA;
    localparam logic [3:0] OP_RD_STORED    = 4'hB;
    localparam logic [3:0] OP_WR_STORED    = 4'hC;
    localparam logic [3:0] OP_COPY_TO_WIP  = 4'hD;
    localparam logic [3:0] OP_COPY_TO_STO  = 4'hE;
    localparam logic [3:0] OP_GANG_TO_WIP  = 4'h1;
    localparam logic [3:0] OP_GANG_TO_STO  = 4'h8;
    localparam logic [3:0] OP_STEP         = 4'h2;

    // Timing
    localparam int CLK_KHZ       = 250000;
    localparam int NV_PROG_MS    = 5;
    localparam int SETTLE_NS_DEF = 1000;
    localparam int NV_CNT_W      = 24;
    localparam int SETTLE_W      = 16;

    typedef logic [NV_CNT_W-1:0] qpcd_nvcnt_t;
    typedef logic [SETTLE_W-1:0] qpcd_settle_t;

    typedef enum logic [2:0] {
        PH_BOOT,
        PH_IDLE,
        PH_ADDR,
        PH_INSTR,
        PH_WDATA,
        PH_RDATA,
        PH_STEP,
        PH_WAIT
    } qpcd_ph_e;

    typedef struct packed {
        qpcd_ph_e                         ph;
        logic [3:0]                       bit_cnt;
        logic                             ack_phase;
        logic [7:0]                       shreg;
        logic [3:0]                       op;
        logic [1:0]                       slot;
        logic [1:0]                       pot;
        logic                             sda_oe;
        logic                             sda_lvl;
        logic                             scl_prev;
        logic                             sda_prev;
        logic                             nv_pend;
        logic [WIPER_W-1:0]               nv_val;
        logic                             nv_busy;
        qpcd_nvcnt_t                      nv_cnt;
        qpcd_settle_t                     settle_cnt;
        logic [NPOTS-1:0][WIPER_W-1:0]    wiper;
        logic [NREGS-1:0][WIPER_W-1:0]    stored;
        logic [NPOTS-1:0][NTAPS-1:0]      tap;
    } qpcd_state_s;

    function automatic logic [3:0] qpcd_sidx(input logic [1:0] pot, input logic [1:0] slot);
        return {pot, slot};
    endfunction : qpcd_sidx

    function automatic logic [NTAPS-1:0] qpcd_tap(input logic [WIPER_W-1:0] w);
        return NTAPS'(1) << w;
    endfunction : qpcd_tap

    function automatic logic qpcd_instr_ok(input logic [7:0] b);
        logic [3:0] op;
        logic       r0;
        logic       p0;
        op = b[OP_HI:OP_LO];
        r0 = (b[SLOT_HI:SLOT_LO] == SEL_ZERO);
        p0 = (b[POT_HI:POT_LO] == SEL_ZERO);
        unique case (op)
            OP_RD_WIPER, OP_WR_WIPER, OP_STEP:          return r0;
            OP_RD_STORED, OP_WR_STORED:                 return 1'b1;
            OP_COPY_TO_WIP, OP_COPY_TO_STO:             return 1'b1;
            OP_GANG_TO_WIP, OP_GANG_TO_STO:             return p0;
            default:                                    return 1'b0;
        endcase
    endfunction : qpcd_instr_ok

endpackage : qpcd_pkg

// ---- rtl/qpcd_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module qpcd_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    // Idle-high reset keeps a released bus from looking like an edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= '1;
            sync_o <= '1;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : qpcd_sync
`default_nettype wire

// ---- verif/qpcd_master.sv ----
`timescale 1ns/10ps
`default_nettype none
module qpcd_master (
    // Clock
    input  wire logic clk_i,
    // Bus wire
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_o
);
    // Both lines released at rest; clock stands still between frames
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // Data moves only while the clock is low; one bit is 20 clocks
    task automatic bit_io(input logic b, output logic r);
        sda_o <= b;
        tick(5);
        scl_o <= 1'b1;
        tick(5);
        r = sda_i;
        tick(5);
        scl_o <= 1'b0;
        tick(5);
    endtask : bit_io

    task automatic start();
        sda_o <= 1'b1;
        scl_o <= 1'b1;
        tick(10);
        sda_o <= 1'b0;
        tick(10);
        scl_o <= 1'b0;
        tick(5);
    endtask : start

    task automatic stop();
        sda_o <= 1'b0;
        tick(5);
        scl_o <= 1'b1;
        tick(10);
        sda_o <= 1'b1;
        tick(10);
    endtask : stop

    task automatic byte_out(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : byte_out

    // Single byte only, so the master never acknowledges it
    task automatic byte_in(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
    endtask : byte_in
endmodule : qpcd_master
`default_nettype wire

// ---- verif/quad_pot_command_decoder_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module quad_pot_command_decoder_tb;
    import qpcd_pkg::*;
    localparam logic [3:0] DEV_ID = 4'h6; // Arbitrary value
    logic                            clk = 1'b0;
    logic                            rst = 1'b1;
    logic                            wp_n = 1'b1;
    logic [3:0]                      pins = 4'h0;
    logic                            scl;
    logic                            m_sda;
    logic                            sda_o;
    logic                            sda_oe;
    logic                            sda_w;
    logic                            busy;
    logic [NPOTS-1:0][NTAPS-1:0]     taps;
    logic [5:0]                      wip [4];
    logic [5:0]                      sto [16];
    logic [31:0]                     rs = 32'h0000FAFC;
    int                              failures = 0;
    int                              checks_done = 0;

    always #2 clk = ~clk;
    assign sda_w = m_sda & (~sda_oe | sda_o);

    qpcd_top #(.DEVICE_TYPE_ID(DEV_ID), .NV_PROG_CYC(300), .WIPER_SETTLE_NS(20)) dut (
        .CLOCK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o),
        .SDA_OE_O(sda_oe), .ADDR_PIN_I(pins), .WP_N_I(wp_n), .TAP_O(taps), .NV_BUSY_O(busy));
    qpcd_master m (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));

    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : rnd

    function automatic logic defd(input logic [3:0] op, input logic [1:0] sl, input logic [1:0] pt);
        case (op)
            4'h9, 4'hA, 4'h2: return sl == 2'h0;
            4'hB, 4'hC, 4'hD, 4'hE: return 1'b1;
            4'h1, 4'h8: return pt == 2'h0;
            default: return 1'b0;
        endcase
    endfunction : defd

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic model_reset();
        foreach (wip[p]) wip[p] = 6'h00;
        foreach (sto[s]) sto[s] = 6'h00;
    endtask : model_reset

    task automatic cmd(input logic [3:0] op, input logic [1:0] sl, input logic [1:0] pt,
                       input logic [7:0] d, input int ns);
        logic       a;
        logic       ok;
        logic       nv;
        logic [7:0] rd;
        logic [3:0] i;
        i = {pt, sl};
        ok = defd(op, sl, pt);
        nv = 1'b0;
        m.start();
        m.byte_out({DEV_ID, pins}, a);
        chk(a, 1'b1, "address ack");
        m.byte_out({op, sl, pt}, a);
        chk(a, ok, "instruction ack");
        if (ok)
        begin
            case (op)
                4'h9:
                begin
                    m.byte_in(rd);
                    chk(rd, {2'h0, wip[pt]}, "wiper read");
                end
                4'hA:
                begin
                    m.byte_out(d, a);
                    chk(a, 1'b1, "wiper write ack");
                    wip[pt] = d[5:0];
                end
                4'hB:
                begin
                    m.byte_in(rd);
                    chk(rd, {2'h0, sto[i]}, "stored read");
                end
                4'hC:
                begin
                    m.byte_out(d, a);
                    chk(a, wp_n, "stored write ack");
                    nv = wp_n;
                    if (wp_n) sto[i] = d[5:0];
                end
                4'hD: wip[pt] = sto[i];
                4'hE:
                begin
                    nv = wp_n;
                    if (wp_n) sto[i] = wip[pt];
                end
                4'h1: for (int p = 0; p < 4; p++) wip[p] = sto[p*4+sl];
                4'h8:
                begin
                    nv = wp_n;
                    for (int p = 0; p < 4; p++) if (wp_n) sto[p*4+sl] = wip[p];
                end
                default:
                begin
                    for (int n = 0; n < ns; n++)
                    begin
                        m.bit_io(d[n], a);
                        if (d[n] && wip[pt] != 6'h3F) wip[pt]++;
                        if (!d[n] && wip[pt] != 6'h00) wip[pt]--;
                    end
                end
            endcase
        end
        m.stop();
        if (nv)
        begin
            chk(busy, 1'b1, "programming started");
            m.start();
            m.byte_out({DEV_ID, pins}, a);
            chk(a, 1'b0, "address during programming");
            m.stop();
            for (int n = 0; n < 400 && busy !== 1'b0; n++) m.tick(1);
            chk(busy, 1'b0, "programming finished");
        end
        m.tick(20);
        for (int p = 0; p < 4; p++) chk(taps[p], 64'h1 << wip[p], "tap");
    endtask : cmd

    task automatic results();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    initial
    begin
        #300000;
        failures++;
        results();
    end

    initial
    begin : main
        logic [31:0] r;
        logic        a;
        model_reset();
        m.tick(6);
        rst <= 1'b0;
        r = rnd();
        pins <= r[3:0];
        m.tick(10);
        m.start();
        m.byte_out({~DEV_ID, pins}, a);
        chk(a, 1'b0, "foreign type");
        m.stop();
        m.start();
        m.byte_out({DEV_ID, ~pins}, a);
        chk(a, 1'b0, "foreign pins");
        m.stop();
        // Three rounds of all sixteen codes; later rounds clear the slot pointer
        for (int k = 0; k < 48; k++)
        begin
            r = rnd();
            pins <= r[15:12];
            wp_n <= r[16] | r[17];
            cmd(4'(k), (k < 16) ? r[9:8] : 2'h0, r[11:10], r[7:0], 8);
        end
        cmd(4'hA, 2'h0, 2'h1, 8'h3E, 0);
        cmd(4'h2, 2'h0, 2'h1, 8'hFF, 4);
        cmd(4'hA, 2'h0, 2'h1, 8'h01, 0);
        cmd(4'h2, 2'h0, 2'h1, 8'h00, 4);
        wp_n <= 1'b0;
        m.tick(5);
        cmd(4'hC, 2'h2, 2'h3, 8'(rnd() >> 24), 0);
        cmd(4'hE, 2'h1, 2'h2, 8'h00, 0);
        cmd(4'h8, 2'h3, 2'h0, 8'h00, 0);
        cmd(4'hB, 2'h2, 2'h3, 8'h00, 0);
        wp_n <= 1'b1;
        rst <= 1'b1;
        m.tick(3);
        rst <= 1'b0;
        model_reset();
        m.tick(20);
        cmd(4'h9, 2'h0, 2'h2, 8'h00, 0);
        results();
    end
endmodule : quad_pot_command_decoder_tb
`default_nettype wire
